// ===== rtl/ivc_pkg.sv
// Operation
// RULE1: Vector slots at top hold handler addresses
// RULE2: Reset-class sources vector through top word
// RULE3: Fetch from registers or hole resets
// RULE4: Priority-14 group ignores global enable
// RULE5: Converter flags share priority-12 vector
// RULE6: Timer channel 0 owns priority-6 vector
// RULE7: Channels 1, 2, overflow share priority 5
// RULE8: Port one flags share priority 4
// RULE9: Port two flags share priority 1
// RULE10: Source flags stay in their modules
// RULE11: Watchdog enable acts only in interval mode
// RULE12: Watchdog flag sets on overflow or key
// RULE13: Watchdog flag clears on power-up, pin reset
// RULE14: Oscillator fault flag with own enable
// RULE15: Pin event sets NMI flag, own enable
// RULE16: Flash violation has its own enable
// RULE17: Serial receive vectored at priority 9
// RULE18: Serial transmit vectored at priority 8
// RULE19: Tick timer takes lowest vector
// RULE20: Unassigned register bits are absent
// RULE21: Highest pending enabled priority wins
// RULE22: Serial module enables clear on power-up clear
package ivc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned IVC_ADDR_W = 8;
  localparam logic [7:0] IVC_OFF_IE1 = 8'h00;
  localparam logic [7:0] IVC_OFF_IE2 = 8'h04;
  localparam logic [7:0] IVC_OFF_IFG1 = 8'h08;
  localparam logic [7:0] IVC_OFF_IFG2 = 8'h0C;
  localparam logic [7:0] IVC_OFF_ME1 = 8'h10;
  localparam logic [7:0] IVC_OFF_STAT = 8'h14;

  // Bit positions
  localparam int IVC_B_WDT = 0;
  localparam int IVC_B_OSC = 1;
  localparam int IVC_B_NMI = 4;
  localparam int IVC_B_FLASH = 5;
  localparam int IVC_B_RX = 6;
  localparam int IVC_B_TX = 7;
  localparam int IVC_B_TICK = 7;
  localparam int IVC_B_ME_RX = 6;
  localparam int IVC_B_ME_TX = 7;

  // Implemented bits
  localparam logic [7:0] IVC_IE1_MASK = 8'hF3;
  localparam logic [7:0] IVC_IE2_MASK = 8'h80;
  localparam logic [7:0] IVC_IFG1_MASK = 8'hD3;
  localparam logic [7:0] IVC_IFG2_MASK = 8'h80;
  localparam logic [7:0] IVC_ME1_MASK = 8'hC0;
  localparam logic [7:0] IVC_REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Vectors and priorities
  // ----------------------------------------------------------------
  localparam int unsigned IVC_NPRI = 16;
  localparam logic [15:0] IVC_VEC_BASE = 16'hFFE0;
  localparam logic [3:0] IVC_PRI_RESET = 4'hF;
  localparam int IVC_PRI_NMI = 14;
  localparam int IVC_PRI_MBOX = 13;
  localparam int IVC_PRI_ADC = 12;
  localparam int IVC_PRI_WDT = 10;
  localparam int IVC_PRI_RX = 9;
  localparam int IVC_PRI_TX = 8;
  localparam int IVC_PRI_CC0 = 6;
  localparam int IVC_PRI_TA = 5;
  localparam int IVC_PRI_P1 = 4;
  localparam int IVC_PRI_P2 = 1;
  localparam int IVC_PRI_TICK = 0;

  // Illegal fetch ranges
  localparam logic [15:0] IVC_PERIPH_HI = 16'h01FF;
  localparam logic [15:0] IVC_HOLE_LO = 16'h0600;
  localparam logic [15:0] IVC_HOLE_HI = 16'h0BFF;

  // Requests and events from the surrounding modules
  typedef struct packed {
    logic adc_overflow_flag;
    logic adc_result_flag;
    logic mailbox_in_flag;
    logic mailbox_out_flag;
    logic [2:0] compare_channel_flag;
    logic timer_overflow_flag;
    logic [7:0] port_one_edge_flags;
    logic [7:0] port_two_edge_flags;
    logic flash_violation_flag;
    logic flash_key_violation;
    logic osc_fault_detect;
    logic nmi_pin_event;
    logic watchdog_overflow;
    logic serial_rx_event;
    logic serial_tx_event;
    logic tick_event;
  } ivc_src_t;

  function automatic logic [15:0] ivc_vector(input logic [3:0] pri);
    ivc_vector = IVC_VEC_BASE + {11'h000, pri, 1'b0};
  endfunction : ivc_vector

endpackage : ivc_pkg

// ===== rtl/ivc_prio_enc.sv
module ivc_prio_enc
  import ivc_pkg::*;
#(
  parameter int unsigned N = IVC_NPRI
)(
  input wire logic [N-1:0] req,
  output logic valid,
  output logic [$clog2(N)-1:0] idx
);

  // Higher index overwrites lower, so the top request wins
  always_comb
  begin
    valid = 1'b0;
    idx = '0;
    for (int i = 0; i < N; i++)
    begin
      if (req[i])
      begin
        valid = 1'b1;
        idx = i[$clog2(N)-1:0]; // see RULE21
      end
    end
  end

endmodule : ivc_prio_enc

// ===== rtl/ivc_fetch_guard.sv
module ivc_fetch_guard
  import ivc_pkg::*;
(
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  output logic illegal
);

  // Register space or the unused hole
  assign illegal = fetch_valid && ((fetch_addr <= IVC_PERIPH_HI) ||
                   ((fetch_addr >= IVC_HOLE_LO) && (fetch_addr <= IVC_HOLE_HI))); // see RULE3

endmodule : ivc_fetch_guard

// ===== rtl/ivc_top.sv
module ivc_top
  import ivc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [IVC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ivc_src_t src,
  input wire logic gie,
  input wire logic wdt_interval_mode,
  input wire logic nmi_pin_mode,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [3:0] irq_prio,
  output logic puc,
  output logic serial_rx_module_enable,
  output logic serial_tx_module_enable
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] ie1;
  logic [7:0] ie2;
  logic [7:0] ifg1;
  logic [7:0] ifg2;
  logic [7:0] me1;
  logic [3:0] reset_cause;
  logic [7:0] next_ifg1;
  logic [7:0] next_ifg2;
  logic [7:0] set1;
  logic [7:0] clr1;
  logic [IVC_NPRI-1:0] req;
  logic pend_valid;
  logic [3:0] pend_idx;
  logic illegal_fetch;
  logic pin_reset_evt;
  logic wdt_reset_evt;
  logic puc_evt;
  logic setup_phase;
  logic access_phase;
  logic wr_en;
  logic acked;

  function automatic logic ivc_mapped(input logic [IVC_ADDR_W-1:0] a);
    ivc_mapped = (a == IVC_OFF_IE1) || (a == IVC_OFF_IE2) || (a == IVC_OFF_IFG1) ||
                 (a == IVC_OFF_IFG2) || (a == IVC_OFF_ME1) || (a == IVC_OFF_STAT);
  endfunction : ivc_mapped

  // ----------------------------------------------------------------
  // Reset-class events
  // ----------------------------------------------------------------
  ivc_fetch_guard u_fetch_guard (
    .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr),
    .illegal(illegal_fetch)
  );

  assign pin_reset_evt = src.nmi_pin_event && !nmi_pin_mode;
  assign wdt_reset_evt = src.watchdog_overflow && !wdt_interval_mode;
  // Every reset-class source ends in the same system reset
  assign puc_evt = pin_reset_evt || wdt_reset_evt || src.flash_key_violation || illegal_fetch; // see RULE2

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      puc <= 1'b1; // see RULE2
    else
      puc <= puc_evt; // see RULE3
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      reset_cause <= 4'h0;
    else if (puc_evt)
      reset_cause <= {illegal_fetch, src.flash_key_violation, wdt_reset_evt, pin_reset_evt};
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access_phase && !ivc_mapped(paddr);
  assign wr_en = access_phase && pwrite && pstrb[0];

  // Read data is captured in the setup cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (setup_phase)
    begin
      unique case (paddr)
        IVC_OFF_IE1: prdata <= {24'h00_0000, ie1};
        IVC_OFF_IE2: prdata <= {24'h00_0000, ie2};
        IVC_OFF_IFG1: prdata <= {24'h00_0000, ifg1};
        IVC_OFF_IFG2: prdata <= {24'h00_0000, ifg2};
        IVC_OFF_ME1: prdata <= {24'h00_0000, me1};
        IVC_OFF_STAT: prdata <= {4'h0, reset_cause, 3'h0, irq_req, irq_prio, irq_vector};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || puc)
      ie1 <= IVC_REG_RESET;
    else if (wr_en && paddr == IVC_OFF_IE1)
      ie1 <= pwdata[7:0] & IVC_IE1_MASK; // see RULE20
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn || puc)
      ie2 <= IVC_REG_RESET;
    else if (wr_en && paddr == IVC_OFF_IE2)
      ie2 <= pwdata[7:0] & IVC_IE2_MASK; // see RULE20
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn || puc)
      me1 <= IVC_REG_RESET; // see RULE22
    else if (wr_en && paddr == IVC_OFF_ME1)
      me1 <= pwdata[7:0] & IVC_ME1_MASK;
  end

  assign serial_rx_module_enable = me1[IVC_B_ME_RX];
  assign serial_tx_module_enable = me1[IVC_B_ME_TX];

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  assign acked = irq_ack && irq_req;

  always_comb
  begin
    set1 = 8'h00;
    set1[IVC_B_WDT] = src.watchdog_overflow || src.flash_key_violation; // see RULE12
    set1[IVC_B_OSC] = src.osc_fault_detect; // see RULE14
    set1[IVC_B_NMI] = src.nmi_pin_event && nmi_pin_mode; // see RULE15
    set1[IVC_B_RX] = src.serial_rx_event;
    set1[IVC_B_TX] = src.serial_tx_event;
    clr1 = 8'h00;
    clr1[IVC_B_WDT] = acked && irq_prio == 4'(IVC_PRI_WDT);
    clr1[IVC_B_RX] = acked && irq_prio == 4'(IVC_PRI_RX);
    clr1[IVC_B_TX] = acked && irq_prio == 4'(IVC_PRI_TX);
  end

  // Hardware set wins over any clear in the same cycle
  always_comb
  begin
    next_ifg1 = ifg1 & ~clr1;
    if (wr_en && paddr == IVC_OFF_IFG1)
      next_ifg1 = pwdata[7:0] & IVC_IFG1_MASK & ~clr1;
    if (pin_reset_evt)
      next_ifg1[IVC_B_WDT] = 1'b0; // see RULE13
    next_ifg1 = next_ifg1 | set1;
  end

  always_comb
  begin
    next_ifg2 = ifg2;
    if (acked && irq_prio == 4'(IVC_PRI_TICK))
      next_ifg2[IVC_B_TICK] = 1'b0;
    if (wr_en && paddr == IVC_OFF_IFG2)
      next_ifg2 = pwdata[7:0] & IVC_IFG2_MASK;
    next_ifg2[IVC_B_TICK] = next_ifg2[IVC_B_TICK] || src.tick_event;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      ifg1 <= IVC_REG_RESET; // see RULE13
    else
      ifg1 <= next_ifg1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      ifg2 <= IVC_REG_RESET;
    else
      ifg2 <= next_ifg2;
  end

  // ----------------------------------------------------------------
  // Request vector
  // ----------------------------------------------------------------
  // Shared sources are ORed; except the flags held in ifg1 and ifg2, their flags live in their own modules
  always_comb
  begin
    req = '0;
    req[IVC_PRI_NMI] = (ifg1[IVC_B_NMI] && ie1[IVC_B_NMI]) ||
                       (ifg1[IVC_B_OSC] && ie1[IVC_B_OSC]) ||
                       (src.flash_violation_flag && ie1[IVC_B_FLASH]); // see RULE4 RULE16
    req[IVC_PRI_MBOX] = gie && (src.mailbox_in_flag || src.mailbox_out_flag); // see RULE10
    req[IVC_PRI_ADC] = gie && (src.adc_overflow_flag || src.adc_result_flag); // see RULE5
    req[IVC_PRI_WDT] = gie && wdt_interval_mode && ifg1[IVC_B_WDT] && ie1[IVC_B_WDT]; // see RULE11
    req[IVC_PRI_RX] = gie && ifg1[IVC_B_RX] && ie1[IVC_B_RX]; // see RULE17
    req[IVC_PRI_TX] = gie && ifg1[IVC_B_TX] && ie1[IVC_B_TX]; // see RULE18
    req[IVC_PRI_CC0] = gie && src.compare_channel_flag[0]; // see RULE6
    req[IVC_PRI_TA] = gie && (src.compare_channel_flag[1] || src.compare_channel_flag[2] ||
                              src.timer_overflow_flag); // see RULE7
    req[IVC_PRI_P1] = gie && (|src.port_one_edge_flags); // see RULE8
    req[IVC_PRI_P2] = gie && (|src.port_two_edge_flags); // see RULE9
    req[IVC_PRI_TICK] = gie && ifg2[IVC_B_TICK] && ie2[IVC_B_TICK]; // see RULE19
  end

  ivc_prio_enc #(
    .N(IVC_NPRI)
  ) u_prio_enc (
    .req(req),
    .valid(pend_valid),
    .idx(pend_idx)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      irq_req <= 1'b0;
      irq_prio <= IVC_PRI_RESET;
    end
    else
    begin
      irq_req <= pend_valid && !puc && !puc_evt;
      irq_prio <= puc ? IVC_PRI_RESET : pend_idx; // see RULE21
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      irq_vector <= ivc_vector(IVC_PRI_RESET);
    else if (puc)
      irq_vector <= ivc_vector(IVC_PRI_RESET); // see RULE2
    else
      irq_vector <= ivc_vector(pend_idx); // see RULE1
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_reset_evt;
    puc_evt;
  endsequence

  sequence s_reset_out;
    puc ##1 (irq_vector == IVC_VEC_BASE + 16'h001E && !irq_req);
  endsequence

  a_reset_vector_path: assert property (s_reset_evt |=> s_reset_out) // see RULE2
    else $error("reset event did not reach reset vector");

  a_fetch_hole_reset: assert property ( // see RULE3
    (fetch_valid && fetch_addr >= IVC_HOLE_LO && fetch_addr <= IVC_HOLE_HI) |=> puc)
    else $error("fetch from hole gave no reset");

  a_vector_matches_prio: assert property ( // see RULE1
    irq_req |-> irq_vector == IVC_VEC_BASE + {11'h000, irq_prio, 1'b0})
    else $error("vector does not match priority");

  a_nmi_no_gie: assert property ( // see RULE4
    (!gie && ifg1[IVC_B_NMI] && ie1[IVC_B_NMI] && !puc && !puc_evt) |=>
      (irq_req && irq_prio == 4'hE))
    else $error("nmi blocked by global enable");

  a_wdt_mode_masks: assert property ( // see RULE11
    !wdt_interval_mode |-> !req[IVC_PRI_WDT])
    else $error("watchdog request in watchdog mode");

  a_wdt_flag_sets: assert property ( // see RULE12
    (src.watchdog_overflow || src.flash_key_violation) |=> ifg1[IVC_B_WDT])
    else $error("watchdog flag not set");

  a_wdt_flag_pin_clr: assert property ( // see RULE13
    (pin_reset_evt && !src.watchdog_overflow && !src.flash_key_violation) |=> !ifg1[IVC_B_WDT])
    else $error("watchdog flag not cleared by pin reset");

  a_rx_outranks_tx: assert property ( // see RULE21
    (req[IVC_PRI_RX] && req[IVC_PRI_TX] && !puc && !puc_evt) |=> (irq_req && irq_prio >= 4'h9))
    else $error("transmit beat receive");

  a_tick_lowest: assert property ( // see RULE19
    (req[IVC_PRI_TICK] && req[IVC_PRI_P2] && !puc && !puc_evt) |=> irq_prio != 4'h0)
    else $error("tick beat port two");

  a_me_puc_clear: assert property (puc |=> me1 == 8'h00) // see RULE22
    else $error("module enables survive reset");

  a_unused_bits_zero: assert property ( // see RULE20
    ((ie1 & ~IVC_IE1_MASK) == 8'h00) && ((ifg1 & ~IVC_IFG1_MASK) == 8'h00))
    else $error("absent bit holds a one");

  a_fetch_reg_reset: assert property ( // see RULE3
    (fetch_valid && fetch_addr <= IVC_PERIPH_HI) |=> puc)
    else $error("fetch from register space gave no reset");

  a_puc_hides_req: assert property (puc_evt |=> !irq_req) // see RULE2
    else $error("request shown during system reset");

  a_gie_masks_all: assert property ( // see RULE4
    !gie |=> (!irq_req || irq_prio == 4'hE))
    else $error("maskable request passed global mask");

  a_osc_flag_sets: assert property (src.osc_fault_detect |=> ifg1[IVC_B_OSC]) // see RULE14
    else $error("oscillator fault flag not set");

  a_nmi_flag_sets: assert property ( // see RULE15
    (src.nmi_pin_event && nmi_pin_mode) |=> ifg1[IVC_B_NMI])
    else $error("pin event did not set nmi flag");

  a_flash_enable_path: assert property ( // see RULE16
    (src.flash_violation_flag && ie1[IVC_B_FLASH] && !puc && !puc_evt) |=> (irq_req && irq_prio == 4'hE))
    else $error("flash violation not requested");

  a_rx_ack_clears: assert property ( // see RULE17
    (acked && irq_prio == 4'h9 && !src.serial_rx_event) |=> !ifg1[IVC_B_RX])
    else $error("receive flag survived accept");

  a_tick_ack_clears: assert property ( // see RULE19
    (acked && irq_prio == 4'h0 && !src.tick_event && !(wr_en && paddr == IVC_OFF_IFG2)) |=> !ifg2[IVC_B_TICK])
    else $error("tick flag survived accept");

endmodule : ivc_top

// ===== testbench/ivc_cpu_model.sv
module ivc_cpu_model
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  input wire logic irq_req,
  output logic irq_ack
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] wait_cnt;

  // ----------------------------------------------------------------
  // Core accepts a request ack_delay+1 cycles after it is raised
  // ----------------------------------------------------------------
  // Restart after each accept, so two accepts are never closer than the output lag
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !ack_en || !irq_req || irq_ack)
    begin
      wait_cnt <= 4'h0;
      irq_ack <= 1'b0;
    end
    else
    begin
      wait_cnt <= wait_cnt + 4'h1;
      irq_ack <= (wait_cnt == ack_delay);
    end
  end
endmodule : ivc_cpu_model

// ===== testbench/test_interrupt_vector_and_sfr_flags.sv
module test_interrupt_vector_and_sfr_flags;
  timeunit 1ns;
  timeprecision 1ns;
  import ivc_pkg::*;

  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb, irq_prio, ack_delay;
  ivc_src_t src, s;
  logic gie, wdt_interval_mode, nmi_pin_mode, fetch_valid, irq_ack, irq_req, puc, e, ack_en;
  logic [15:0] fetch_addr, irq_vector;
  logic rx_en, tx_en;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  ivc_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src(src), .gie(gie), .wdt_interval_mode(wdt_interval_mode), .nmi_pin_mode(nmi_pin_mode),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .irq_ack(irq_ack), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_prio(irq_prio), .puc(puc), .serial_rx_module_enable(rx_en),
    .serial_tx_module_enable(tx_en));

  ivc_cpu_model cpu_u (.sys_clk(sys_clk), .rstn(rstn), .ack_en(ack_en), .ack_delay(ack_delay),
    .irq_req(irq_req), .irq_ack(irq_ack));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
    chk(e, 1'b0, "write error");
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, {24'h00_0000, x}, "read data");
  endtask : rd

  task wait_irq(input logic [15:0] v);
    int n;
    n = 0;
    while (irq_req !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(irq_req, 1'b1, "request raised");
    chk(irq_vector, v, "vector");
    chk(irq_prio, v[4:1], "priority");
  endtask : wait_irq

  task wait_low;
    int n;
    n = 0;
    while (irq_req !== 1'b0 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(irq_req, 1'b0, "request cleared");
  endtask : wait_low

  task wait_puc;
    int n;
    n = 0;
    while (puc !== 1'b1 && n < 10)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(puc, 1'b1, "system reset");
    repeat (3) @(posedge sys_clk);
  endtask : wait_puc

  task pulse(input ivc_src_t p);
    @(posedge sys_clk);
    src <= p;
    @(posedge sys_clk);
    src <= '0;
  endtask : pulse

  task lvl(input ivc_src_t p, input logic [15:0] v);
    src <= p;
    wait_irq(v);
    src <= '0;
    wait_low();
  endtask : lvl

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rstn, psel, penable, pwrite, gie, fetch_valid} = '0;
    {paddr, pwdata, fetch_addr} = '0;
    pstrb = 4'hF;
    src = '0;
    wdt_interval_mode = 1'b1;
    nmi_pin_mode = 1'b1;
    ack_en = 1'b1;
    ack_delay = 4'h3;
    repeat (4) @(posedge sys_clk);
    chk(irq_vector, 16'hFFFE, "reset vector");
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(IVC_OFF_ME1, 8'h00);
    wr(IVC_OFF_IE1, 8'hFF);
    rd(IVC_OFF_IE1, 8'hF3);
    wr(IVC_OFF_IE2, 8'hFF);
    rd(IVC_OFF_IE2, 8'h80);
    wr(IVC_OFF_ME1, 8'hFF);
    rd(IVC_OFF_ME1, 8'hC0);
    chk({rx_en, tx_en}, 2'b11, "module enables");
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(e, 1'b1, "unmapped error");
    $display("test registers done");
    gie <= 1'b1;
    wr(IVC_OFF_IE1, 8'hC1);
    s = '0;
    s.serial_rx_event = 1'b1;
    pulse(s);
    wait_irq(16'hFFF2);
    wait_low();
    ack_delay <= 4'h8;
    s = '0;
    s.serial_tx_event = 1'b1;
    pulse(s);
    wait_irq(16'hFFF0);
    wait_low();
    s = '0;
    s.tick_event = 1'b1;
    pulse(s);
    wait_irq(16'hFFE0);
    wait_low();
    s = '0;
    s.watchdog_overflow = 1'b1;
    pulse(s);
    wait_irq(16'hFFF4);
    wait_low();
    ack_delay <= 4'h3;
    s = '0;
    s.adc_overflow_flag = 1'b1;
    lvl(s, 16'hFFF8);
    s = '0;
    s.mailbox_out_flag = 1'b1;
    lvl(s, 16'hFFFA);
    s = '0;
    s.compare_channel_flag = 3'b001;
    lvl(s, 16'hFFEC);
    s = '0;
    s.compare_channel_flag = 3'b100;
    lvl(s, 16'hFFEA);
    s = '0;
    s.timer_overflow_flag = 1'b1;
    lvl(s, 16'hFFEA);
    s = '0;
    s.port_one_edge_flags = 8'h80;
    lvl(s, 16'hFFE8);
    s = '0;
    s.port_two_edge_flags = 8'h01;
    lvl(s, 16'hFFE2);
    s.compare_channel_flag = 3'b001;
    lvl(s, 16'hFFEC);
    $display("test maskable vectors done");
    gie <= 1'b0;
    src <= s;
    repeat (4) @(posedge sys_clk);
    chk(irq_req, 1'b0, "global mask");
    src <= '0;
    wr(IVC_OFF_IE1, 8'h32);
    s = '0;
    s.nmi_pin_event = 1'b1;
    pulse(s);
    wait_irq(16'hFFFC);
    wr(IVC_OFF_IFG1, 8'h00);
    wait_low();
    s = '0;
    s.osc_fault_detect = 1'b1;
    pulse(s);
    wait_irq(16'hFFFC);
    wr(IVC_OFF_IFG1, 8'h00);
    wait_low();
    s = '0;
    s.flash_violation_flag = 1'b1;
    lvl(s, 16'hFFFC);
    $display("test nonmaskable done");
    wr(IVC_OFF_ME1, 8'hC0);
    s = '0;
    s.flash_key_violation = 1'b1;
    pulse(s);
    wait_puc();
    rd(IVC_OFF_ME1, 8'h00);
    apb(1'b0, IVC_OFF_STAT, 32'h0000_0000);
    chk(r, 32'h0400_FFE0, "reset cause");
    rd(IVC_OFF_IFG1, 8'h01);
    nmi_pin_mode <= 1'b0;
    s = '0;
    s.nmi_pin_event = 1'b1;
    pulse(s);
    wait_puc();
    rd(IVC_OFF_IFG1, 8'h00);
    nmi_pin_mode <= 1'b1;
    wdt_interval_mode <= 1'b0;
    s = '0;
    s.watchdog_overflow = 1'b1;
    pulse(s);
    wait_puc();
    rd(IVC_OFF_IFG1, 8'h01);
    fetch_valid <= 1'b1;
    fetch_addr <= 16'h0200;
    repeat (4) @(posedge sys_clk);
    chk(puc, 1'b0, "legal fetch");
    fetch_addr <= 16'h0700;
    wait_puc();
    fetch_addr <= 16'h0200;
    repeat (2) @(posedge sys_clk);
    fetch_addr <= 16'h01FF;
    wait_puc();
    fetch_valid <= 1'b0;
    $display("test reset sources done");
    test_done();
  end
endmodule : test_interrupt_vector_and_sfr_flags
